// ### civ_core.v
// Interrupt gathering, arbitration and entry sequencing
// Summary of operation
// - Entry waits until current instruction completes
// - Push registers on entry; return pops them
// - Entry sets global mask bit
// - Latched request cannot be preempted
// - Final step loads PC from vector
// - Evaluate pending requests at boundary if unmasked
// - Lowest priority number serviced first
// - Pending request entered right after return
// - High index register never pushed
// - Software trap always interrupts
// - Trap stacks PC; hardware stacks PC minus one
// - Fixed priority and vector per source
// - Global mask gates all but trap
// - Breakpoint match forces software trap
// - Low external pin latches request flag
// - Clock fail while watching sets flag
// - Timer one wrap sets wrap flag
// - Timer one channel event sets flag
// - Timer two wrap sets wrap flag
// - Timer two channel event sets flag
// - Status bits show each request present
`timescale 1ns/1ps
`default_nettype none
`include "civ_defs.vh"
module civ_core #(
    parameter NSRC = `CIV_NUM_SRC
) (
    // Clock and reset
    input wire clk_sys,
    input wire reset,
    // Core sequencer handshake
    input wire insn_done,
    input wire trap_insn,
    input wire return_insn,
    input wire break_match,
    input wire [7:0] ccr_in,
    input wire [15:0] pc_in,
    input wire [7:0] acc_in,
    input wire [7:0] idx_lo_in,
    // Entry outputs to core
    output wire entry_busy,
    output reg push_valid,
    output reg [7:0] push_data,
    output reg set_imask,
    output reg load_pc,
    output reg [15:0] vector_pc,
    output reg pop_request,
    // External pin, active low, and clock monitor
    input wire ext_pin_n,
    input wire ext_pin_req_mask,
    input wire ext_pin_ack,
    input wire clock_watch_enable,
    input wire clock_inactive,
    input wire clock_fail_irq_enable,
    input wire clock_fail_ack,
    // Timer one
    input wire [15:0] t1_count,
    input wire t1_mod_match,
    input wire [1:0] t1_chan_event,
    input wire [1:0] t1_channel_irq_enable,
    input wire [1:0] t1_channel_ack,
    input wire t1_wrap_irq_enable,
    input wire t1_wrap_ack,
    // Timer two
    input wire [15:0] t2_count,
    input wire t2_mod_match,
    input wire [1:0] t2_chan_event,
    input wire [1:0] t2_channel_irq_enable,
    input wire [1:0] t2_channel_ack,
    input wire t2_wrap_irq_enable,
    input wire t2_wrap_ack,
    // Other peripheral flags and enables
    input wire sync_rx_full_flag,
    input wire sync_rx_irq_enable,
    input wire sync_rx_overrun_flag,
    input wire sync_select_fault_flag,
    input wire sync_error_irq_enable,
    input wire sync_tx_empty_flag,
    input wire sync_tx_irq_enable,
    input wire async_rx_overrun_flag,
    input wire async_overrun_irq_enable,
    input wire async_noise_flag,
    input wire async_noise_irq_enable,
    input wire async_framing_flag,
    input wire async_framing_irq_enable,
    input wire async_parity_flag,
    input wire async_parity_irq_enable,
    input wire async_rx_full_flag,
    input wire async_rx_irq_enable,
    input wire async_quiet_flag,
    input wire async_quiet_irq_enable,
    input wire async_tx_empty_flag,
    input wire async_tx_irq_enable,
    input wire async_tx_done_flag,
    input wire async_tx_done_irq_enable,
    input wire keypad_req_flag,
    input wire keypad_req_mask,
    input wire conversion_done_flag,
    input wire conversion_irq_enable,
    input wire tick_rollover_flag,
    input wire tick_irq_enable,
    // Status
    output reg [NSRC-1:0] source_pending_status_bits,
    output wire ext_pin_req_flag,
    output wire clock_fail_flag,
    output wire [1:0] t1_channel_event_flag,
    output wire t1_counter_wrap_flag,
    output wire [1:0] t2_channel_event_flag,
    output wire t2_counter_wrap_flag
);
    ////////////////////////////////////////////////////////////////////
    localparam ST_IDLE = 4'b0001;
    localparam ST_PUSH = 4'b0010;
    localparam ST_VECT = 4'b0100;
    localparam ST_RUN = 4'b1000;

    // Vector for a hardware source index: one word step per priority
    function [15:0] vec_of;
        input [3:0] idx;
        begin
            vec_of = `CIV_VEC_TOP - ({12'h000, idx} << 1);
        end
    endfunction

    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [2:0] stk_q;
    reg is_trap_q;
    reg [3:0] sel_q;
    reg [15:0] pc_q;
    reg [7:0] acc_q;
    reg [7:0] xl_q;
    reg [7:0] ccr_q;
    reg ext_flag_q;
    reg cm_flag_q;
    reg [1:0] t1_ch_q;
    reg [1:0] t2_ch_q;
    reg t1_wr_q;
    reg t2_wr_q;
    reg [NSRC-1:0] vreq;
    wire any_req;
    wire [3:0] win_idx;
    wire boundary;
    wire take_trap;
    wire take_hw;

    ////////////////////////////////////////////////////////////////////
    // Hardware-set flags; set beats a same-cycle acknowledge
    assign ext_pin_req_flag = ext_flag_q;
    assign clock_fail_flag = cm_flag_q;
    assign t1_channel_event_flag = t1_ch_q;
    assign t2_channel_event_flag = t2_ch_q;
    assign t1_counter_wrap_flag = t1_wr_q;
    assign t2_counter_wrap_flag = t2_wr_q;

    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            ext_flag_q <= 1'b0;
            cm_flag_q <= 1'b0;
            t1_wr_q <= 1'b0;
            t2_wr_q <= 1'b0;
        end
        else
        begin
            ext_flag_q <= ~ext_pin_n | (ext_flag_q & ~ext_pin_ack);
            cm_flag_q <= (clock_watch_enable & clock_inactive) | (cm_flag_q & ~clock_fail_ack);
            t1_wr_q <= (t1_mod_match & (t1_count == `CIV_CNT_ZERO)) | (t1_wr_q & ~t1_wrap_ack);
            t2_wr_q <= (t2_mod_match & (t2_count == `CIV_CNT_ZERO)) | (t2_wr_q & ~t2_wrap_ack);
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_chan
            always @(posedge clk_sys or posedge reset)
            begin
                if (reset)
                begin
                    t1_ch_q[g] <= 1'b0;
                    t2_ch_q[g] <= 1'b0;
                end
                else
                begin
                    t1_ch_q[g] <= t1_chan_event[g] | (t1_ch_q[g] & ~t1_channel_ack[g]);
                    t2_ch_q[g] <= t2_chan_event[g] | (t2_ch_q[g] & ~t2_channel_ack[g]);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // One request line per vector, index 0 is priority 1
    always @*
    begin
        vreq = {NSRC{1'b0}};
        vreq[0] = ext_flag_q & ~ext_pin_req_mask;
        vreq[1] = cm_flag_q & clock_fail_irq_enable;
        vreq[2] = t1_ch_q[0] & t1_channel_irq_enable[0];
        vreq[3] = t1_ch_q[1] & t1_channel_irq_enable[1];
        vreq[4] = t1_wr_q & t1_wrap_irq_enable;
        vreq[5] = t2_ch_q[0] & t2_channel_irq_enable[0];
        vreq[6] = t2_ch_q[1] & t2_channel_irq_enable[1];
        vreq[7] = t2_wr_q & t2_wrap_irq_enable;
        vreq[8] = (sync_rx_full_flag & sync_rx_irq_enable)
            | ((sync_rx_overrun_flag | sync_select_fault_flag) & sync_error_irq_enable);
        vreq[9] = sync_tx_empty_flag & sync_tx_irq_enable;
        vreq[10] = (async_rx_overrun_flag & async_overrun_irq_enable)
            | (async_noise_flag & async_noise_irq_enable)
            | (async_framing_flag & async_framing_irq_enable)
            | (async_parity_flag & async_parity_irq_enable);
        vreq[11] = (async_rx_full_flag & async_rx_irq_enable)
            | (async_quiet_flag & async_quiet_irq_enable);
        vreq[12] = (async_tx_empty_flag & async_tx_irq_enable)
            | (async_tx_done_flag & async_tx_done_irq_enable);
        // Keypad mask is a disable, like the pin mask
        vreq[13] = keypad_req_flag & ~keypad_req_mask;
        vreq[14] = conversion_done_flag & conversion_irq_enable;
        vreq[15] = tick_rollover_flag & tick_irq_enable;
    end

    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            source_pending_status_bits <= {NSRC{1'b0}};
        else
            source_pending_status_bits <= vreq;
    end

    civ_prio_enc #(
        .N(NSRC),
        .W(4)
    ) u_enc (
        .req(vreq),
        .any(any_req),
        .idx(win_idx)
    );

    ////////////////////////////////////////////////////////////////////
    // act only at instruction boundary
    assign boundary = insn_done & (state_q == ST_RUN);
    // trap ignores mask; break forces trap
    assign take_trap = boundary & (trap_insn | break_match);
    assign take_hw = boundary & ~take_trap & any_req & ~ccr_in[`CIV_CCR_IMASK];
    assign entry_busy = (state_q == ST_PUSH) | (state_q == ST_VECT);

    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: state_d = ST_RUN;
            ST_RUN:
            begin
                if (take_trap | take_hw)
                    state_d = ST_PUSH;
            end
            ST_PUSH:
            begin
                if (stk_q == `CIV_STK_LAST)
                    state_d = ST_VECT;
            end
            ST_VECT: state_d = ST_RUN;
            default: state_d = ST_IDLE;
        endcase
    end

    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_q <= ST_IDLE;
            stk_q <= 3'h0;
            is_trap_q <= 1'b0;
            sel_q <= 4'h0;
            pc_q <= 16'h0000;
            acc_q <= 8'h00;
            xl_q <= 8'h00;
            ccr_q <= 8'h00;
            push_valid <= 1'b0;
            push_data <= 8'h00;
            set_imask <= 1'b0;
            load_pc <= 1'b0;
            vector_pc <= 16'h0000;
            pop_request <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            push_valid <= 1'b0;
            set_imask <= 1'b0;
            load_pc <= 1'b0;
            // return pops registers; next boundary re-arbitrates
            pop_request <= boundary & return_insn & ~take_trap;
            if (state_q == ST_IDLE)
            begin
                // Reset vector fetched once out of reset
                load_pc <= 1'b1;
                vector_pc <= `CIV_VEC_RESET;
            end
            if (take_trap | take_hw)
            begin
                is_trap_q <= take_trap;
                sel_q <= win_idx;
                // trap keeps PC, hardware PC minus one
                pc_q <= take_trap ? pc_in : pc_in - `CIV_PC_DEC;
                acc_q <= acc_in;
                xl_q <= idx_lo_in;
                ccr_q <= ccr_in;
                stk_q <= 3'h0;
            end
            if (state_q == ST_PUSH)
            begin
                // push PCL, PCH, X, A, CCR; high index skipped
                push_valid <= 1'b1;
                case (stk_q)
                    `CIV_STK_PCL: push_data <= pc_q[7:0];
                    `CIV_STK_PCH: push_data <= pc_q[15:8];
                    `CIV_STK_XL: push_data <= xl_q;
                    `CIV_STK_ACC: push_data <= acc_q;
                    `CIV_STK_CCR: push_data <= ccr_q;
                    default: push_data <= 8'h00;
                endcase
                stk_q <= stk_q + 3'h1;
            end
            if (state_q == ST_VECT)
            begin
                set_imask <= 1'b1;
                load_pc <= 1'b1;
                vector_pc <= is_trap_q ? `CIV_VEC_TRAP : vec_of(sel_q);
            end
        end
    end
endmodule // civ_core
`default_nettype wire

// ### civ_defs.vh
// Constants for the interrupt priority and vectoring block
`ifndef CIV_DEFS_VH
`define CIV_DEFS_VH
`define CIV_NUM_SRC 16
`define CIV_VEC_RESET 16'hFFFE
`define CIV_VEC_TRAP 16'hFFFC
`define CIV_VEC_TOP 16'hFFFA
`define CIV_VEC_STEP 16'h0002
`define CIV_PC_DEC 16'h0001
`define CIV_CNT_ZERO 16'h0000
`define CIV_CCR_IMASK 3
`define CIV_STK_PCL 3'h0
`define CIV_STK_PCH 3'h1
`define CIV_STK_XL 3'h2
`define CIV_STK_ACC 3'h3
`define CIV_STK_CCR 3'h4
`define CIV_STK_LAST 3'h4
`endif

// ### civ_prio_enc.v
// Fixed priority encoder: lowest index wins
`timescale 1ns/1ps
`default_nettype none
module civ_prio_enc #(
    parameter N = 16,
    parameter W = 4
) (
    // Requests
    input wire [N-1:0] req,
    // Result
    output reg any,
    output reg [W-1:0] idx
);
    integer i;
    always @*
    begin
        any = 1'b0;
        idx = {W{1'b0}};
        for (i = N - 1; i >= 0; i = i - 1)
        begin
            if (req[i])
            begin
                any = 1'b1;
                idx = i[W-1:0];
            end
        end
    end
endmodule // civ_prio_enc
`default_nettype wire

// ### civ_core_props.sv
// Port-level assertions for the interrupt priority and vectoring block
`timescale 1ns/1ps
`default_nettype none
module civ_core_props (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Core side
    input wire logic insn_done,
    input wire logic trap_insn,
    input wire logic return_insn,
    input wire logic break_match,
    input wire logic [7:0] ccr_in,
    input wire logic entry_busy,
    input wire logic push_valid,
    input wire logic [7:0] push_data,
    input wire logic set_imask,
    input wire logic load_pc,
    input wire logic [15:0] vector_pc,
    input wire logic pop_request,
    // Flag sources
    input wire logic clock_watch_enable,
    input wire logic clock_inactive,
    input wire logic clock_fail_flag,
    input wire logic [15:0] t1_count,
    input wire logic t1_mod_match,
    input wire logic t1_counter_wrap_flag
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    a_reset_vector: assert property ($fell(reset)
        |-> ##[0:1] load_pc && vector_pc == 16'hFFFE) else $error("reset vector missing");
    a_trap_entry_walk: assert property (insn_done && !entry_busy && (trap_insn || break_match)
        |-> ##2 push_valid [*5] ##1 set_imask && load_pc && vector_pc == 16'hFFFC)
        else $error("trap entry sequence wrong");
    a_ccr_stacked_last: assert property (insn_done && !entry_busy && trap_insn
        |-> ##6 push_data == $past(ccr_in, 6)) else $error("condition codes not last on stack");
    a_mask_with_load: assert property (set_imask |-> load_pc && $past(push_valid))
        else $error("mask set outside entry end");
    a_masked_ignored: assert property (insn_done && !entry_busy && ccr_in[3] && !trap_insn
        && !break_match |=> !entry_busy) else $error("entry while masked");
    a_push_while_busy: assert property (push_valid |-> entry_busy)
        else $error("push outside entry");
    a_return_pop: assert property (insn_done && !entry_busy && return_insn |=> pop_request)
        else $error("no pop after return");
    a_wrap_flag_set: assert property (t1_mod_match && t1_count == 16'h0000
        |=> t1_counter_wrap_flag) else $error("wrap flag not set");
    a_clock_fail_set: assert property (clock_watch_enable && clock_inactive
        |=> clock_fail_flag) else $error("clock fail flag not set");
endmodule // civ_core_props

bind civ_core civ_core_props u_civ_core_props (.*);
`default_nettype wire

// ### civ_cpu_model.sv
// Behavioural core sequencer facing the interrupt block
`timescale 1ns/1ps
`default_nettype none
module civ_cpu_model (
    // Clock
    input wire logic clk_sys,
    // From the interrupt block
    input wire logic entry_busy,
    input wire logic push_valid,
    input wire logic [7:0] push_data,
    input wire logic set_imask,
    input wire logic load_pc,
    input wire logic [15:0] vector_pc,
    input wire logic pop_request,
    // To the interrupt block
    output logic insn_done,
    output logic trap_insn,
    output logic return_insn,
    output logic break_match,
    output logic [7:0] ccr_in,
    output logic [15:0] pc_in,
    output logic [7:0] acc_in,
    output logic [7:0] idx_lo_in
);
    logic [7:0] stack_q [$];
    int loads = 0;
    int pops = 0;

    initial
        {insn_done, trap_insn, return_insn, break_match, ccr_in, pc_in, acc_in, idx_lo_in} = 44'h0;

    always @(posedge clk_sys)
    begin
        if (push_valid)
            stack_q.push_back(push_data);
        if (set_imask)
            ccr_in[3] <= 1'b1;
        if (load_pc)
        begin
            loads++;
            pc_in <= vector_pc;
        end
        if (pop_request)
            pops++;
    end

    // Boundary is never offered while an entry stalls the core
    task automatic step(input logic t, r, b, input logic [7:0] c, a, x, input logic [15:0] p);
        while (entry_busy)
            @(posedge clk_sys) #1;
        {trap_insn, return_insn, break_match, ccr_in, acc_in, idx_lo_in, pc_in} = {t, r, b, c, a, x, p};
        insn_done = 1'b1;
        @(posedge clk_sys);
        #1;
        {insn_done, trap_insn, return_insn, break_match} = 4'h0;
    endtask
endmodule // civ_cpu_model
`default_nettype wire

// ### civ_core_bench.sv
// Self-checking bench for the interrupt priority and vectoring block
`timescale 1ns/1ps
`default_nettype none
module civ_core_bench;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic insn_done, trap_insn, return_insn, break_match, entry_busy, push_valid;
    logic set_imask, load_pc, pop_request, ci, en;
    logic [7:0] ccr_in, acc_in, idx_lo_in, push_data, ls, la, le, ml, c, a, x;
    logic [15:0] pc_in, vector_pc, c1, c2, ex, ev, ps, p;
    logic [14:0] pf, pe;
    logic [2:0] k;
    logic [7:0] eb [5];
    wire [7:0] gf;
    wire [15:0] st;
    int seed = 32'h779c15c9;
    int failures = 0;
    int check_count = 0;
    int idx, ld, pp;

    civ_core u_civ_core (.*,
        .ext_pin_n(~ls[0]), .ext_pin_req_mask(~le[0]), .ext_pin_ack(la[0]),
        .clock_watch_enable(ls[1]), .clock_inactive(ci), .clock_fail_irq_enable(le[1]),
        .clock_fail_ack(la[1]), .t1_count(c1), .t1_mod_match(ls[4]), .t1_chan_event(ls[3:2]),
        .t1_channel_irq_enable(le[3:2]), .t1_channel_ack(la[3:2]), .t1_wrap_irq_enable(le[4]),
        .t1_wrap_ack(la[4]), .t2_count(c2), .t2_mod_match(ls[7]), .t2_chan_event(ls[6:5]),
        .t2_channel_irq_enable(le[6:5]), .t2_channel_ack(la[6:5]), .t2_wrap_irq_enable(le[7]),
        .t2_wrap_ack(la[7]), .sync_rx_full_flag(pf[0]), .sync_rx_irq_enable(pe[0]),
        .sync_rx_overrun_flag(pf[1]), .sync_select_fault_flag(pf[2]),
        .sync_error_irq_enable(pe[1]), .sync_tx_empty_flag(pf[3]), .sync_tx_irq_enable(pe[3]),
        .async_rx_overrun_flag(pf[4]), .async_overrun_irq_enable(pe[4]),
        .async_noise_flag(pf[5]), .async_noise_irq_enable(pe[5]), .async_framing_flag(pf[6]),
        .async_framing_irq_enable(pe[6]), .async_parity_flag(pf[7]),
        .async_parity_irq_enable(pe[7]), .async_rx_full_flag(pf[8]), .async_rx_irq_enable(pe[8]),
        .async_quiet_flag(pf[9]), .async_quiet_irq_enable(pe[9]), .async_tx_empty_flag(pf[10]),
        .async_tx_irq_enable(pe[10]), .async_tx_done_flag(pf[11]),
        .async_tx_done_irq_enable(pe[11]), .keypad_req_flag(pf[12]), .keypad_req_mask(~pe[12]),
        .conversion_done_flag(pf[13]), .conversion_irq_enable(pe[13]),
        .tick_rollover_flag(pf[14]), .tick_irq_enable(pe[14]), .source_pending_status_bits(st),
        .ext_pin_req_flag(gf[0]), .clock_fail_flag(gf[1]), .t1_channel_event_flag(gf[3:2]),
        .t1_counter_wrap_flag(gf[4]), .t2_channel_event_flag(gf[6:5]),
        .t2_counter_wrap_flag(gf[7]));
    civ_cpu_model u_civ_cpu_model (.*);

    always #5 clk_sys = ~clk_sys;

    // Latched flags: a set in the same cycle as its clear wins
    always @(posedge clk_sys or posedge reset)
        if (reset)
            ml <= 8'h00;
        else
            ml <= ls & {c2 == 16'h0000, 2'h3, c1 == 16'h0000, 2'h3, ci, 1'b1} | ml & ~la;

    function automatic logic [15:0] exp_status();
        logic [14:0] q;
        q = pf & {pe[14:3], pe[1], pe[1:0]};
        return {q[14:12], |q[11:10], |q[9:8], |q[7:4], q[3], |q[2:0], ml & le};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // About 80 rounds of 15 cycles; over sixteen times that before giving up
    initial
    begin
        #200000;
        failures++;
        end_sim();
    end

    initial
    begin
        {pf, pe, ls, le, la, ci, c1, c2} = 87'h0;
        repeat (16) @(posedge clk_sys);
        #1 reset = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 chk(16'(u_civ_cpu_model.loads), 16'h0001);
        chk(u_civ_cpu_model.pc_in, 16'hFFFE);
        repeat (80)
        begin
            {ls, la, ci} = 17'($random(seed));
            {pf, pe} = 30'($random(seed));
            le = 8'($random(seed));
            c1 = ci ? 16'h0000 : 16'($random(seed));
            c2 = la[7] ? 16'h0000 : 16'($random(seed));
            @(posedge clk_sys);
            #1 {ls, la} = 16'h0000;
            repeat (3) @(posedge clk_sys);
            #1 chk({8'h00, gf}, {8'h00, ml});
            ex = exp_status();
            chk(st, ex);
            {k, c, a, x} = 27'($random(seed));
            p = 16'($random(seed));
            idx = 16;
            for (int i = 15; i >= 0; i--)
                if (ex[i])
                    idx = i;
            if (k == 3'h2)
                c[3] = 1'b1;
            en = k < 3'h2 || (!c[3] && idx < 16);
            ev = k < 3'h2 ? 16'hFFFC : 16'hFFFA - 16'(2 * idx);
            ps = k < 3'h2 ? p : p - 16'h0001;
            ld = u_civ_cpu_model.loads;
            pp = u_civ_cpu_model.pops;
            u_civ_cpu_model.stack_q.delete();
            u_civ_cpu_model.step(k == 3'h0, k == 3'h2, k == 3'h1, c, a, x, p);
            // Late requests must not displace the one already taken
            pf = 15'($random(seed));
            repeat (10) @(posedge clk_sys);
            #1 chk(16'(u_civ_cpu_model.loads - ld), {15'h0, en});
            chk(16'(u_civ_cpu_model.pops - pp), {15'h0, k == 3'h2});
            if (en)
            begin
                chk(u_civ_cpu_model.pc_in, ev);
                chk({15'h0, u_civ_cpu_model.ccr_in[3]}, 16'h0001);
                chk(16'(u_civ_cpu_model.stack_q.size()), 16'h0005);
                eb = '{ps[7:0], ps[15:8], x, a, c};
                for (int i = 0; i < 5; i++)
                    chk({8'h00, u_civ_cpu_model.stack_q[i]}, {8'h00, eb[i]});
            end
        end
        end_sim();
    end
endmodule // civ_core_bench
`default_nettype wire
